// [verilog/alc_pkg.sv]
// Constants and types for the access level and indicator block
// How it works
// - Read level is always open; parameters can only be read there.
// - Code equal to operator password opens operator level, default 0001.
// - Configuration password, default 0002, opens configuration level.
// - Open level closes after 10 minutes without key or local-port setting.
// - Code 9999 closes the open operator or configuration level at once.
// - Setting state is granted only with the matching level already open; the code grants it whenever operator or configuration level is open.
// - Help plus enter starts entry; right moves, up steps, enter submits.
// - Passwords change only over the local serial port, never from keypad.
// - Power indicator lit while supply present and unit running.
// - Fault lights error LED and requests reboot; lit while it persists.
// - Communication indicator follows serial bus activity.
// - Alarm LED follows its assigned matrix signals, or holds if latched.
// - Trip LED follows its assigned matrix signals, or holds if latched.
// - Three application indicators A to C with selectable sources.
// - Alarm, trip, application indicators and every output relay have a latch option held until reset.
// - Cancel held 3 s leaves alarm list; enter then clears all latches.
// - Enter acks each alarm entry, then enter at initial clears latches.
// - Bus reset command or configured digital input also clears all latches.
package alc_pkg;
	localparam int          CLK_HZ       = 250_000_000;
	localparam int          IDLE_MIN     = 10;
	localparam int          HOLD_MS      = 3000;
	localparam longint      IDLE_CYC     = longint'(IDLE_MIN) * 60 * CLK_HZ;
	localparam longint      HOLD_CYC     = longint'(HOLD_MS) * (CLK_HZ / 1000);
	localparam logic [15:0] OPER_PW_RST  = 16'h0001;
	localparam logic [15:0] CONF_PW_RST  = 16'h0002;
	localparam logic [15:0] CLOSE_CODE   = 16'h9999;
	localparam logic [3:0]  DIGIT_MAX    = 4'h9;
	localparam logic [7:0]  OFS_LEVEL    = 8'h00;
	localparam logic [7:0]  OFS_OPERPW   = 8'h04;
	localparam logic [7:0]  OFS_CONFPW   = 8'h08;
	localparam logic [7:0]  OFS_LATCH    = 8'h0C;
	localparam logic [7:0]  OFS_MAP      = 8'h10;
	localparam logic [7:0]  OFS_STATUS   = 8'h14;
	localparam logic [7:0]  OFS_CMD      = 8'h18;
	localparam int          CMD_CLR_BIT  = 0;
	localparam int          MAP_DI_BIT   = 30;
	localparam int          NLED         = 5;

	typedef enum logic [2:0] {
		LVL_USER = 3'b001,
		LVL_OPER = 3'b010,
		LVL_CONF = 3'b100
	} alc_level_e;

	typedef enum logic [2:0] {
		DSP_INIT  = 3'b001,
		DSP_ALARM = 3'b010,
		DSP_PASS  = 3'b100
	} alc_disp_e;

	typedef struct packed {
		logic helpKey;
		logic enterKey;
		logic cancelKey;
		logic rightKey;
		logic upKey;
	} alc_keys_s;

	typedef struct packed {
		logic       power;
		logic       error;
		logic       com;
		logic       alarm;
		logic       trip;
		logic [2:0] app;
	} alc_leds_s;
endpackage

// [verilog/alc_latch_cell.sv]
// One indicator or relay output with optional latching
`timescale 1ns/1ns
module alc_latch_cell (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	input  wire logic src,
	input  wire logic latchEn,
	input  wire logic clr,
	output      logic q
);
	logic q_ff;

	// Active source beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q_ff <= 1'b0;
		end else if (ce) begin
			q_ff <= src | (latchEn & q_ff & ~clr);
		end
	end
	assign q = q_ff;

	AST_LATCH_HOLD: assert property (@(posedge clk)
		disable iff (sys_rst) ce && latchEn && q_ff && !clr |=> q_ff)
		else $error("latched output dropped without reset");
	AST_FOLLOW: assert property (@(posedge clk)
		disable iff (sys_rst) ce && !latchEn && !src |=> !q_ff)
		else $error("unlatched output did not follow source");
endmodule

// [verilog/alc_top.sv]
// Access levels, password entry and front-panel indicators
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module alc_top import alc_pkg::*; #(
	parameter longint IDLE_LIMIT = IDLE_CYC,
	parameter longint HOLD_LIMIT = HOLD_CYC,
	parameter int     NSIG       = 8,
	parameter int     NREL       = 8
) (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic            ce,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output      logic [31:0]     prdata,
	output      logic            pready,
	output      logic            pslverr,
	input  wire alc_keys_s       keys,
	input  wire logic            settingReq,
	input  wire logic            unitRunning,
	input  wire logic            internalFault,
	input  wire logic            busActive,
	input  wire logic            busLatchReset,
	input  wire logic            digital_input_line,
	input  wire logic            alarmEvent,
	input  wire logic [NSIG-1:0] matrixSig,
	input  wire logic [3:0]      appSrc,
	input  wire logic [NREL-1:0] relaySrc,
	output      alc_level_e      level,
	output      alc_disp_e       disp,
	output      logic            readPerm,
	output      logic            operPerm,
	output      logic            confPerm,
	output      logic            settingGrant,
	output      logic            rebootReq,
	output      alc_leds_s       leds,
	output      logic [NREL-1:0] relays
);
	alc_level_e      level_ff;
	alc_disp_e       disp_ff;
	alc_keys_s       keysQ_ff;
	logic [31:0]     prdata_ff;
	logic            pready_ff;
	logic            pslverr_ff;
	logic [15:0]     operPw_ff;
	logic [15:0]     confPw_ff;
	logic [NLED+NREL-1:0] latchCfg_ff;
	logic [31:0]     map_ff;
	logic [15:0]     pwDig_ff;
	logic [1:0]      pwPos_ff;
	logic [39:0]     idle_ff;
	logic [39:0]     hold_ff;
	logic [3:0]      pend_ff;
	logic            busClr_ff;
	logic            operPerm_ff;
	logic            confPerm_ff;
	logic            grant_ff;
	logic            reboot_ff;
	logic            faultQ_ff;
	logic            power_ff;
	logic            com_ff;
	logic            errLed_ff;
	logic [NLED+NREL-1:0] cellSrc;
	logic [NLED+NREL-1:0] cellQ;
	alc_keys_s       press;
	logic            apbAcc;
	logic            apbWr;
	logic            mapped;
	logic            submit;
	logic            enterAlone;
	logic            clrAll;
	logic            activity;
	logic [15:0]     nxt_pwDig;

	assign press      = keys & ~keysQ_ff;
	assign apbAcc     = psel & penable & pready_ff;
	assign apbWr      = apbAcc & pwrite;
	assign submit     = disp_ff == DSP_PASS && press.enterKey;
	assign enterAlone = press.enterKey & ~keys.helpKey;
	assign activity   = |press | apbWr;

	// Latches cleared from keypad, bus command or digital input
	assign clrAll = (disp_ff == DSP_INIT && enterAlone && pend_ff == 4'h0)
		| busClr_ff | busLatchReset
		| (map_ff[MAP_DI_BIT] & digital_input_line);

	always_comb begin
		if (apbWr && paddr == OFS_MAP) begin
			mapped = 1'b1;
		end else if (paddr == OFS_LEVEL || paddr == OFS_OPERPW) begin
			mapped = 1'b1;
		end else if (paddr == OFS_CONFPW || paddr == OFS_LATCH) begin
			mapped = 1'b1;
		end else if (paddr == OFS_MAP || paddr == OFS_STATUS) begin
			mapped = 1'b1;
		end else if (paddr == OFS_CMD) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// One wait state so every answer comes from a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else if (ce) begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
			prdata_ff  <= 32'h0000_0000;
			if (psel && penable && !pready_ff && !pwrite) begin
				if (paddr == OFS_LEVEL) begin
					prdata_ff <= {25'h0, disp_ff, 1'b0, level_ff};
				end else if (paddr == OFS_OPERPW) begin
					prdata_ff <= {16'h0, operPw_ff};
				end else if (paddr == OFS_CONFPW) begin
					prdata_ff <= {16'h0, confPw_ff};
				end else if (paddr == OFS_LATCH) begin
					prdata_ff <= 32'(latchCfg_ff);
				end else if (paddr == OFS_MAP) begin
					prdata_ff <= map_ff;
				end else if (paddr == OFS_STATUS) begin
					prdata_ff <= {12'h0, pend_ff, 8'(relays), leds};
				end
			end
		end
	end

	// Passwords have no keypad write path at all
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			operPw_ff   <= OPER_PW_RST;
			confPw_ff   <= CONF_PW_RST;
			latchCfg_ff <= '0;
			map_ff      <= 32'h0000_0000;
			busClr_ff   <= 1'b0;
		end else if (ce) begin
			busClr_ff <= apbWr && paddr == OFS_CMD
				&& pwdata[CMD_CLR_BIT];
			if (apbWr && paddr == OFS_OPERPW) begin
				operPw_ff <= pwdata[15:0];
			end else if (apbWr && paddr == OFS_CONFPW) begin
				confPw_ff <= pwdata[15:0];
			end else if (apbWr && paddr == OFS_LATCH) begin
				latchCfg_ff <= pwdata[NLED+NREL-1:0];
			end else if (apbWr && paddr == OFS_MAP) begin
				map_ff <= pwdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			keysQ_ff <= '0;
		end else if (ce) begin
			keysQ_ff <= keys;
		end
	end

	// Digit entry; an up press wraps nine back to zero
	always_comb begin
		nxt_pwDig = pwDig_ff;
		if (pwDig_ff[pwPos_ff*4 +: 4] == DIGIT_MAX) begin
			nxt_pwDig[pwPos_ff*4 +: 4] = 4'h0;
		end else begin
			nxt_pwDig[pwPos_ff*4 +: 4] = pwDig_ff[pwPos_ff*4 +: 4] + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwDig_ff <= 16'h0000;
			pwPos_ff <= 2'h0;
		end else if (ce) begin
			if (disp_ff != DSP_PASS) begin
				pwDig_ff <= 16'h0000;
				pwPos_ff <= 2'h0;
			end else if (press.rightKey) begin
				pwPos_ff <= pwPos_ff - 2'h1;
			end else if (press.upKey) begin
				pwDig_ff <= nxt_pwDig;
			end
		end
	end

	// Display context drives which meaning enter has
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			disp_ff <= DSP_INIT;
		end else if (ce) begin
			case (disp_ff)
				DSP_INIT: begin
					if (keys.helpKey && keys.enterKey
						&& (press.helpKey || press.enterKey)) begin
						disp_ff <= DSP_PASS;
					end else if (alarmEvent) begin
						disp_ff <= DSP_ALARM;
					end
				end
				DSP_ALARM: begin
					if (hold_ff == 40'(HOLD_LIMIT)) begin
						disp_ff <= DSP_INIT;
					end else if (enterAlone && pend_ff == 4'h1
						&& !alarmEvent) begin
						disp_ff <= DSP_INIT;
					end
				end
				DSP_PASS: begin
					if (press.enterKey || press.cancelKey) begin
						disp_ff <= DSP_INIT;
					end
				end
				default: disp_ff <= DSP_INIT;
			endcase
		end
	end

	// Pending alarm entries; below 15, a new alarm with an acknowledge leaves the count unchanged
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_ff <= 4'h0;
		end else if (ce) begin
			if (disp_ff == DSP_ALARM && hold_ff == 40'(HOLD_LIMIT)) begin
				pend_ff <= {3'h0, alarmEvent};
			end else if (alarmEvent && pend_ff != 4'hF) begin
				if (!(disp_ff == DSP_ALARM && enterAlone)) begin
					pend_ff <= pend_ff + 4'h1;
				end
			end else if (disp_ff == DSP_ALARM && enterAlone
				&& pend_ff != 4'h0) begin
				pend_ff <= pend_ff - 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_ff <= 40'h0;
		end else if (ce) begin
			if (disp_ff == DSP_ALARM && keys.cancelKey) begin
				hold_ff <= hold_ff + 40'h1;
			end else begin
				hold_ff <= 40'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idle_ff <= 40'h0;
		end else if (ce) begin
			if (level_ff == LVL_USER || activity) begin
				idle_ff <= 40'h0;
			end else begin
				idle_ff <= idle_ff + 40'h1;
			end
		end
	end

	// Closing code checked first so it can never open a level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level_ff <= LVL_USER;
		end else if (ce) begin
			if (submit && pwDig_ff == CLOSE_CODE) begin
				level_ff <= LVL_USER;
			end else if (submit && pwDig_ff == confPw_ff) begin
				level_ff <= LVL_CONF;
			end else if (submit && pwDig_ff == operPw_ff) begin
				level_ff <= LVL_OPER;
			end else if (idle_ff == 40'(IDLE_LIMIT) - 40'h1) begin
				level_ff <= LVL_USER;
			end else begin
				level_ff <= level_ff;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			operPerm_ff <= 1'b0;
			confPerm_ff <= 1'b0;
			grant_ff    <= 1'b0;
		end else if (ce) begin
			operPerm_ff <= level_ff != LVL_USER;
			confPerm_ff <= level_ff == LVL_CONF;
			grant_ff    <= settingReq && level_ff != LVL_USER;
		end
	end

	// Reboot is requested once per fault onset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			faultQ_ff <= 1'b0;
			reboot_ff <= 1'b0;
			errLed_ff <= 1'b0;
			power_ff  <= 1'b0;
			com_ff    <= 1'b0;
		end else if (ce) begin
			faultQ_ff <= internalFault;
			reboot_ff <= internalFault & ~faultQ_ff;
			errLed_ff <= internalFault;
			power_ff  <= unitRunning;
			com_ff    <= busActive;
		end
	end

	assign cellSrc = {relaySrc,
		|(matrixSig & map_ff[NSIG-1:0]),
		|(matrixSig & map_ff[NSIG+7:8]),
		appSrc[map_ff[21:20]], appSrc[map_ff[19:18]],
		appSrc[map_ff[17:16]]};

	genvar gi;
	generate
		for (gi = 0; gi < NLED + NREL; gi++) begin : g_cell
			alc_latch_cell u_cell (
				.clk     (clk),
				.sys_rst (sys_rst),
				.ce      (ce),
				.src     (cellSrc[gi]),
				.latchEn (latchCfg_ff[gi]),
				.clr     (clrAll),
				.q       (cellQ[gi])
			);
		end
	endgenerate

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign level        = level_ff;
	assign disp         = disp_ff;
	assign readPerm     = 1'b1;
	assign operPerm     = operPerm_ff;
	assign confPerm     = confPerm_ff;
	assign settingGrant = grant_ff;
	assign rebootReq    = reboot_ff;
	assign leds = {power_ff, errLed_ff, com_ff, cellQ[4:3], cellQ[2:0]};
	assign relays = cellQ[NLED+NREL-1:NLED];

	// All checks share the one block clock and reset
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	AST_CLOSE: assert property (ce && submit
		&& pwDig_ff == CLOSE_CODE |=> level_ff == LVL_USER)
		else $error("closing code did not close level");
	AST_CONF_OPEN: assert property (ce && submit
		&& pwDig_ff == confPw_ff && pwDig_ff != CLOSE_CODE
		|=> level_ff == LVL_CONF)
		else $error("configuration password did not open level");
	AST_OPER_OPEN: assert property (ce && submit
		&& pwDig_ff == operPw_ff && pwDig_ff != confPw_ff
		&& pwDig_ff != CLOSE_CODE |=> level_ff == LVL_OPER)
		else $error("operator password did not open level");
	AST_BAD_CODE: assert property (ce && submit
		&& pwDig_ff != operPw_ff && pwDig_ff != confPw_ff
		&& pwDig_ff != CLOSE_CODE
		&& idle_ff != 40'(IDLE_LIMIT) - 40'h1 |=> $stable(level_ff))
		else $error("unknown code changed level");
	AST_CONF_IMPLIES_OPER: assert property (
		confPerm_ff |-> operPerm_ff)
		else $error("configuration level lacks operator permission");
	AST_GRANT: assert property (ce && settingReq
		&& level_ff == LVL_USER |=> !grant_ff)
		else $error("setting granted at read level");
	AST_IDLE_ACT: assert property (ce && activity
		|=> idle_ff == 40'h0)
		else $error("activity did not restart idle interval");
	AST_PW_LOCK: assert property (ce && !apbWr
		|=> $stable(operPw_ff) && $stable(confPw_ff))
		else $error("password changed without serial port write");
	AST_REBOOT: assert property (ce && internalFault
		&& !faultQ_ff |=> reboot_ff && errLed_ff)
		else $error("fault onset without reboot request");
	AST_BUS_CLR: assert property (ce && busClr_ff
		&& !relaySrc[0] ##1 ce |-> !relays[0])
		else $error("bus reset left relay latched");
	AST_READ_OPEN: assert property (readPerm)
		else $error("read level closed");

	COV_CONF: cover property (
		level_ff == LVL_USER ##1 level_ff == LVL_CONF);
	COV_TIMEOUT: cover property (!activity && level_ff != LVL_USER
		##1 level_ff == LVL_USER);
	COV_ACK: cover property (
		disp_ff == DSP_ALARM ##1 disp_ff == DSP_INIT ##[1:20] clrAll);
endmodule

// [test/alc_panel_model.sv]
// Front-panel keypad model operated by a person
`timescale 1ns/1ns
module alc_panel_model import alc_pkg::*; (
	input  wire logic clk,
	output alc_keys_s keys
);
	initial keys = '0;
	// Release after each press so the next one is a fresh edge
	task automatic press(input alc_keys_s k, input int hold);
		@(posedge clk) keys <= k;
		repeat (hold) @(posedge clk);
		keys <= '0;
		@(posedge clk);
	endtask
	// Digit positions visited 0,3,2,1; enter submits
	task automatic code(input logic [15:0] c);
		press(5'b11000, 1);
		for (int i = 0; i < 4; i++) begin
			if (i > 0)
				press(5'b00010, 1);
			repeat (c[4*((4-i)%4) +: 4]) press(5'b00001, 1);
		end
		press(5'b01000, 1);
	endtask
endmodule

// [test/access_level_and_indicator_control_tb.sv]
// Self-checking bench for the access level and indicator block
`timescale 1ns/1ns
module access_level_and_indicator_control_tb;
	import alc_pkg::*;
	logic        clk = 1'b0;
	logic        sysRst = 1'b1;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr;
	alc_keys_s   keys;
	logic        settingReq = 1'b0;
	logic        unitRunning = 1'b0;
	logic        internalFault = 1'b0;
	logic        busActive = 1'b0;
	logic        busLatchReset = 1'b0;
	logic        diLine = 1'b0;
	logic        alarmEvent = 1'b0;
	logic [7:0]  matrixSig = 8'h00;
	logic [7:0]  relaySrc = 8'h00;
	logic [3:0]  appSrc = 4'h0;
	alc_level_e  level;
	alc_disp_e   disp;
	logic        readPerm, operPerm, confPerm, settingGrant, rebootReq;
	alc_leds_s   leds;
	logic [7:0]  relays;
	logic        rebootSeen = 1'b0;
	logic [31:0] rd;
	logic        er;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #2 clk = ~clk;

	alc_panel_model panel (.clk(clk), .keys(keys));

	// Short idle and hold limits keep the run brief
	alc_top #(.IDLE_LIMIT(50), .HOLD_LIMIT(10)) uut (
		.clk(clk), .sys_rst(sysRst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .keys(keys), .settingReq(settingReq),
		.unitRunning(unitRunning), .internalFault(internalFault),
		.busActive(busActive), .busLatchReset(busLatchReset),
		.digital_input_line(diLine), .alarmEvent(alarmEvent),
		.matrixSig(matrixSig), .appSrc(appSrc), .relaySrc(relaySrc),
		.level(level), .disp(disp), .readPerm(readPerm),
		.operPerm(operPerm), .confPerm(confPerm),
		.settingGrant(settingGrant), .rebootReq(rebootReq),
		.leds(leds), .relays(relays)
	);

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (rebootReq === 1'b1)
			rebootSeen <= 1'b1;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Pre-edge values read after the edge are what the edge sampled
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle pulse: 0 bus reset, 1 input line, 2 alarm entry
	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
			0: busLatchReset <= 1'b1;
			1: diLine <= 1'b1;
			default: alarmEvent <= 1'b1;
		endcase
		@(posedge clk);
		busLatchReset <= 1'b0;
		diLine <= 1'b0;
		alarmEvent <= 1'b0;
		wt(3);
	endtask

	// Trip is unlatched, so it falls back with its source
	task automatic raise();
		@(posedge clk);
		matrixSig <= 8'h03;
		relaySrc <= 8'h01;
		@(posedge clk);
		matrixSig <= 8'h00;
		relaySrc <= 8'h00;
		wt(3);
		check(leds.alarm, 1'b1);
		check(leds.trip, 1'b0);
		check(relays[0], 1'b1);
	endtask

	task automatic submit(input logic [15:0] c, input alc_level_e exp);
		panel.code(c);
		wt(3);
		check(level, exp);
	endtask

	initial begin
		wt(20);
		sysRst <= 1'b0;
		wt(2);
		check(readPerm, 1'b1);
		apb(1'b1, OFS_LEVEL, 32'h4);
		apb(1'b0, OFS_LEVEL, 32'h0);
		check(rd, 32'h11);
		apb(1'b0, OFS_OPERPW, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFS_CONFPW, 32'h0);
		check(rd, 32'h2);
		apb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		check(er, 1'b1);
		settingReq <= 1'b1;
		wt(3);
		check(settingGrant, 1'b0);
		submit(16'h0000, LVL_USER);
		submit(16'h0001, LVL_OPER);
		check({operPerm, confPerm, settingGrant}, 3'b101);
		submit(16'h1234, LVL_OPER);
		submit(16'h9999, LVL_USER);
		check(operPerm, 1'b0);
		submit(16'h0002, LVL_CONF);
		check({operPerm, confPerm}, 2'b11);
		// Key press and port write each restart the idle count
		wt(30);
		panel.press(5'b00010, 1);
		wt(30);
		check(level, LVL_CONF);
		apb(1'b1, OFS_CONFPW, 32'h2);
		wt(30);
		check(level, LVL_CONF);
		wt(30);
		check(level, LVL_USER);
		apb(1'b1, OFS_OPERPW, 32'h5);
		apb(1'b0, OFS_OPERPW, 32'h0);
		check(rd, 32'h5);
		submit(16'h0005, LVL_OPER);
		submit(16'h9999, LVL_USER);
		unitRunning <= 1'b1;
		busActive <= 1'b1;
		internalFault <= 1'b1;
		wt(4);
		check({leds.power, leds.com, leds.error}, 3'b111);
		check(rebootSeen, 1'b1);
		busActive <= 1'b0;
		internalFault <= 1'b0;
		wt(4);
		check({leds.com, leds.error}, 2'b00);
		// Clock enable low must freeze the indicators
		ce <= 1'b0;
		unitRunning <= 1'b0;
		wt(3);
		check(leds.power, 1'b1);
		ce <= 1'b1;
		wt(3);
		check(leds.power, 1'b0);
		apb(1'b1, OFS_MAP, 32'h0002_0201);
		apb(1'b1, OFS_LATCH, 32'h30);
		appSrc <= 4'b0100;
		wt(3);
		check(leds.app, 3'b001);
		raise();
		pulse(0);
		check({leds.alarm, relays[0]}, 2'b00);
		raise();
		apb(1'b1, OFS_MAP, 32'h4002_0201);
		pulse(1);
		check({leds.alarm, relays[0]}, 2'b00);
		raise();
		pulse(2);
		pulse(2);
		check(disp, DSP_ALARM);
		panel.press(5'b01000, 1);
		wt(2);
		check({disp, leds.alarm}, {DSP_ALARM, 1'b1});
		panel.press(5'b01000, 1);
		wt(2);
		check(disp, DSP_INIT);
		panel.press(5'b01000, 1);
		wt(2);
		check({leds.alarm, relays[0]}, 2'b00);
		raise();
		pulse(2);
		panel.press(5'b00100, 15);
		wt(2);
		check(disp, DSP_INIT);
		panel.press(5'b01000, 1);
		wt(2);
		check({leds.alarm, relays[0]}, 2'b00);
		// Clear command over the register bus
		raise();
		apb(1'b1, OFS_CMD, 32'h1);
		wt(2);
		check({leds.alarm, relays[0]}, 2'b00);
		// Reset in mid-run restores the factory password
		sysRst <= 1'b1;
		wt(2);
		sysRst <= 1'b0;
		wt(2);
		apb(1'b0, OFS_OPERPW, 32'h0);
		check(rd, 32'h1);
		finish_test();
	end
endmodule
